// ===== sio_pkg.sv
package sio_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // -------------------------------------------------------------
    localparam logic [3:0] OFS_ENABLE   = 4'h0;     // control_register_0
    localparam logic [3:0] OFS_XFER     = 4'h4;     // control_register_1
    localparam logic [3:0] OFS_MODE     = 4'h8;     // control_register_2 write, status read
    localparam logic [3:0] OFS_DATA     = 4'hC;     // data_buffer
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int         EN_BIT       = 7;        // interface_enable
    localparam int         GO_BIT       = 7;        // transfer_go
    localparam int         ABORT_BIT    = 6;        // transfer_abort
    localparam int         XMODE_LSB    = 4;        // transfer_mode_sel
    localparam int         BUSM_LSB     = 2;        // bus_mode_sel
    localparam int         SIOF_BIT     = 3;        // transfer in progress
    localparam int         SEF_BIT      = 2;        // shift in progress
    // -------------------------------------------------------------
    // encodings and reset values
    // -------------------------------------------------------------
    localparam logic [1:0] XM_TX        = 2'h0;     // transmit only
    localparam logic [1:0] XM_RSV       = 2'h1;     // reserved
    localparam logic [1:0] XM_TXRX      = 2'h2;     // transmit and receive
    localparam logic [1:0] XM_RX        = 2'h3;     // receive only
    localparam logic [1:0] BM_PORT      = 2'h0;     // port mode
    localparam logic [1:0] BM_SIO       = 2'h1;     // serial synchronous mode
    localparam logic [2:0] SCK_EXT      = 3'h7;     // shift clock from pin
    localparam logic [2:0] SCK_RST      = 3'h1;     // clock select after reset
    localparam logic [7:0] XFER_ONES    = 8'h08;    // bit 3 reads one
    localparam logic [7:0] STAT_ONES    = 8'hF3;    // bits 7-4, 1-0 read one
    localparam logic [7:0] BYTE_RST     = 8'h00;    // data buffer reset
    localparam logic [2:0] LAST_BIT     = 3'h7;     // eighth bit index
    localparam logic [1:0] RESP_OKAY    = 2'h0;     // axi okay
    localparam logic [1:0] RESP_SLVERR  = 2'h2;     // axi slave error
endpackage

// ===== sio_ctrl.sv
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
module sio_ctrl
    import sio_pkg::*;
(
    input  wire logic        aclk,        // register clock
    input  wire logic        aresetn,     // sync reset, low active
    input  wire logic        clk_en,      // freezes all state when low
    input  wire logic        shift_clk,   // link clock (divider source, or serial clock pin for SCK_EXT)
    input  wire logic        si_in,       // serial data in
    output logic             so_out,      // serial data out
    output logic             sck_out,     // generated serial clock
    output logic             sck_oe,      // high while sck_out drives pin
    input  wire logic [3:0]  awaddr,      // write address
    input  wire logic        awvalid,     // write address valid
    output logic             awready,     // write address ready
    input  wire logic [31:0] wdata,       // write data
    input  wire logic [3:0]  wstrb,       // write byte enables
    input  wire logic        wvalid,      // write data valid
    output logic             wready,      // write data ready
    output logic [1:0]       bresp,       // write response
    output logic             bvalid,      // write response valid
    input  wire logic        bready,      // write response ready
    input  wire logic [3:0]  araddr,      // read address
    input  wire logic        arvalid,     // read address valid
    output logic             arready,     // read address ready
    output logic [31:0]      rdata,       // read data
    output logic [1:0]       rresp,       // read response
    output logic             rvalid,      // read data valid
    input  wire logic        rready       // read data ready
);
    // -------------------------------------------------------------
    // register-side state
    // -------------------------------------------------------------
    typedef struct packed {
        logic        en;          // interface_enable
        logic        go;          // transfer_go
        logic        abort;       // transfer_abort
        logic [1:0]  xmode;       // transfer_mode_sel
        logic [2:0]  sck;         // clock select
        logic        sck_wr;      // clock select written since reset
        logic [1:0]  busm;        // bus_mode_sel
        logic [7:0]  tx;          // write side of data buffer
        logic        tx_full;     // transmit byte waiting
        logic [7:0]  rx;          // read side of data buffer
        logic [7:0]  src;         // byte handed to link
        logic [1:0]  src_mode;    // mode handed to link
        logic        busy;        // link owns a byte
        logic        aborted;     // current byte was aborted
        logic        start_tgl;   // start event to link
        logic        d1;          // done toggle sync stage 1
        logic        d2;          // done toggle sync stage 2
        logic        dseen;       // done toggle consumed
        logic        wr_rdy;      // awready and wready
        logic        bv;          // bvalid
        logic [1:0]  br;          // bresp
        logic        ar_rdy;      // arready
        logic        rv;          // rvalid
        logic [31:0] rd;          // rdata
        logic [1:0]  rr;          // rresp
    } reg_t;

    // -------------------------------------------------------------
    // link-side state
    // -------------------------------------------------------------
    typedef struct packed {
        logic        s1;          // start sync stage 1
        logic        s2;          // start sync stage 2
        logic        sseen;       // start toggle consumed
        logic        a1;          // abort sync stage 1
        logic        a2;          // abort sync stage 2
        logic [1:0]  en_s;        // enable sync stages
        logic        i1;          // serial input stage 1
        logic        i2;          // serial input stage 2
        logic        active;      // byte in flight
        logic [7:0]  sh;          // transmit shift register
        logic [7:0]  rxs;         // receive shift register
        logic [2:0]  cnt;         // bit index
        logic [6:0]  div;         // clock divider
        logic        sck;         // serial clock level
        logic        oe;          // clock pin enable
        logic        so;          // serial out
        logic        done_tgl;    // done event to register side
    } link_t;

    reg_t  r_ff, nxt_r;           // register-side flops
    link_t l_ff, nxt_l;           // link-side flops
    logic  wr_hs;                 // write handshake this edge
    logic  start_now;             // byte launch this edge

    // address decode used by read and write
    function automatic logic known(input logic [3:0] a);
        known = (a == OFS_ENABLE) || (a == OFS_XFER) || (a == OFS_MODE) || (a == OFS_DATA);
    endfunction

    assign wr_hs     = r_ff.wr_rdy && awvalid && wvalid;
    assign start_now = r_ff.en && r_ff.busm == BM_SIO && r_ff.go && !r_ff.abort && !r_ff.busy
                       && r_ff.xmode != XM_RSV && (r_ff.tx_full || r_ff.xmode == XM_RX);

    // -------------------------------------------------------------
    // register side: bus slave, control, hand-off to link
    // -------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        // write channel: take address and data together, answer next
        nxt_r.wr_rdy = !r_ff.wr_rdy && !r_ff.bv && awvalid && wvalid;
        if (r_ff.bv && bready) begin
            nxt_r.bv = 1'b0;
        end
        if (wr_hs) begin
            nxt_r.bv = 1'b1;
            nxt_r.br = known(awaddr) ? RESP_OKAY : RESP_SLVERR;
        end
        // read channel
        nxt_r.ar_rdy = !r_ff.ar_rdy && !r_ff.rv && arvalid;
        if (r_ff.rv && rready) begin
            nxt_r.rv = 1'b0;
        end
        if (r_ff.ar_rdy && arvalid) begin
            nxt_r.rv = 1'b1;
            nxt_r.rr = known(araddr) ? RESP_OKAY : RESP_SLVERR;
            nxt_r.rd = 32'h0000_0000;
            case (araddr)
                OFS_ENABLE: nxt_r.rd[EN_BIT] = r_ff.en;
                OFS_XFER: begin
                    nxt_r.rd[7:0] = XFER_ONES;
                    nxt_r.rd[GO_BIT] = r_ff.go;
                    nxt_r.rd[ABORT_BIT] = r_ff.abort;
                    nxt_r.rd[XMODE_LSB+:2] = r_ff.xmode;
                    nxt_r.rd[2:0] = r_ff.sck;
                end
                OFS_MODE: begin
                    // bus mode is write only; status shares the word
                    nxt_r.rd[7:0] = STAT_ONES;
                    nxt_r.rd[SIOF_BIT] = r_ff.busy || (r_ff.go && r_ff.tx_full);
                    nxt_r.rd[SEF_BIT] = r_ff.busy;
                end
                OFS_DATA: nxt_r.rd[7:0] = r_ff.rx;  // receive byte only
                default: nxt_r.rd = 32'h0000_0000;
            endcase
        end
        // completion from link: two-flop toggle sync
        nxt_r.d1 = l_ff.done_tgl;
        nxt_r.d2 = r_ff.d1;
        if (r_ff.d2 != r_ff.dseen) begin
            nxt_r.dseen = r_ff.d2;
            nxt_r.busy = 1'b0;
            nxt_r.aborted = 1'b0;
            if (!r_ff.aborted && r_ff.src_mode != XM_TX) begin
                nxt_r.rx = l_ff.rxs;
            end
        end
        if (r_ff.en) begin
            if (r_ff.busy && r_ff.abort) begin
                nxt_r.aborted = 1'b1;
            end
            if (start_now) begin
                nxt_r.busy = 1'b1;
                nxt_r.aborted = 1'b0;                      // no stale abort on a new byte
                nxt_r.src = r_ff.tx;
                nxt_r.src_mode = r_ff.xmode;
                nxt_r.tx_full = 1'b0;
                nxt_r.start_tgl = !r_ff.start_tgl;
            end
        end
        // register writes; with enable low only reg0 has a clock
        if (wr_hs && wstrb[0]) begin
            if (awaddr == OFS_ENABLE) begin
                nxt_r.en = wdata[EN_BIT];
            end
            if (r_ff.en) begin
                case (awaddr)
                    OFS_XFER: begin
                        nxt_r.go = wdata[GO_BIT];
                        nxt_r.abort = wdata[ABORT_BIT];
                        nxt_r.xmode = wdata[XMODE_LSB+:2];
                        nxt_r.sck = wdata[2:0];
                        nxt_r.sck_wr = 1'b1;
                    end
                    OFS_MODE: begin
                        nxt_r.busm = wdata[BUSM_LSB+:2];
                        if (wdata[BUSM_LSB+:2] == BM_SIO && !r_ff.sck_wr) begin
                            nxt_r.sck[0] = 1'b0;
                        end
                    end
                    OFS_DATA: begin
                        nxt_r.tx = wdata[7:0];
                        nxt_r.tx_full = 1'b1;              // set wins over launch
                    end
                    default: ;
                endcase
            end
        end
    end

    // register-side flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= '0;
            r_ff.sck <= SCK_RST;
            r_ff.busm <= BM_PORT;
            r_ff.tx <= BYTE_RST;
            r_ff.rx <= BYTE_RST;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    // -------------------------------------------------------------
    // link side: serial clock and shifter on shift_clk
    // -------------------------------------------------------------
    always_comb begin
        nxt_l = l_ff;
        nxt_l.s1 = r_ff.start_tgl;
        nxt_l.s2 = l_ff.s1;
        nxt_l.a1 = r_ff.abort;
        nxt_l.a2 = l_ff.a1;
        nxt_l.en_s = {l_ff.en_s[0], r_ff.en};
        nxt_l.i1 = si_in;
        nxt_l.i2 = l_ff.i1;
        nxt_l.oe = r_ff.sck != SCK_EXT;
        if (!l_ff.en_s[1]) begin
            // interface disabled: shifter and serial clock hold still
        end else if (l_ff.s2 != l_ff.sseen) begin
            // src and src_mode stay still while busy
            nxt_l.sseen = l_ff.s2;
            nxt_l.active = 1'b1;
            nxt_l.sh = r_ff.src;
            nxt_l.cnt = 3'h0;
            nxt_l.div = 7'h00;
            nxt_l.sck = 1'b1;
        end else if (l_ff.active && l_ff.a2) begin
            nxt_l.active = 1'b0;
            nxt_l.sck = 1'b1;
            nxt_l.done_tgl = !l_ff.done_tgl;
        end else if (l_ff.active) begin
            if (r_ff.sck == SCK_EXT) begin
                // pin clock: one bit per edge
                if (r_ff.src_mode != XM_RX) begin
                    nxt_l.so = l_ff.sh[0];
                end
                nxt_l.sh = l_ff.sh >> 1;
                nxt_l.rxs = {l_ff.i2, l_ff.rxs[7:1]};
                nxt_l.cnt = l_ff.cnt + 3'h1;
                if (l_ff.cnt == LAST_BIT) begin
                    nxt_l.active = 1'b0;
                    nxt_l.done_tgl = !l_ff.done_tgl;
                end
            end else if (l_ff.div == ((7'h01 << r_ff.sck) - 7'h01)) begin
                // half period of 2^sel link cycles
                nxt_l.div = 7'h00;
                nxt_l.sck = !l_ff.sck;
                if (l_ff.sck) begin
                    // leading (falling) edge drives next bit
                    if (r_ff.src_mode != XM_RX) begin
                        nxt_l.so = l_ff.sh[0];
                    end
                    nxt_l.sh = l_ff.sh >> 1;
                end else begin
                    // trailing (rising) edge samples input
                    nxt_l.rxs = {l_ff.i2, l_ff.rxs[7:1]};
                    nxt_l.cnt = l_ff.cnt + 3'h1;
                    if (l_ff.cnt == LAST_BIT) begin
                        nxt_l.active = 1'b0;
                        nxt_l.done_tgl = !l_ff.done_tgl;
                    end
                end
            end else begin
                nxt_l.div = l_ff.div + 7'h01;
            end
        end
    end

    // link-side flops
    always_ff @(posedge shift_clk) begin
        if (!aresetn) begin
            l_ff <= '0;
            l_ff.sck <= 1'b1;
        end else if (clk_en) begin
            l_ff <= nxt_l;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign awready = r_ff.wr_rdy;
    assign wready  = r_ff.wr_rdy;
    assign bvalid  = r_ff.bv;
    assign bresp   = r_ff.br;
    assign arready = r_ff.ar_rdy;
    assign rvalid  = r_ff.rv;
    assign rdata   = r_ff.rd;
    assign rresp   = r_ff.rr;
    assign so_out  = l_ff.so;
    assign sck_out = l_ff.sck;
    assign sck_oe  = l_ff.oe;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_disabled_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
        !r_ff.en && !nxt_r.en |=> $stable(r_ff.go) && $stable(r_ff.tx) && !$rose(r_ff.busy))
        else $error("state moved while disabled");
    a_config_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(r_ff.en) |-> r_ff.xmode == $past(r_ff.xmode) && r_ff.sck == $past(r_ff.sck))
        else $error("disable changed configuration");
    a_start_needs_go: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r_ff.busy) |-> $past(r_ff.go) && $past(r_ff.busm) == BM_SIO)
        else $error("transfer started without go");
    a_abort_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        r_ff.abort && !r_ff.busy && clk_en |=> !r_ff.busy)
        else $error("transfer started under abort");
    a_reserved_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        r_ff.xmode == XM_RSV && !r_ff.busy && clk_en |=> !r_ff.busy)
        else $error("reserved mode started transfer");
    a_sck_bit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hs && wstrb[0] && r_ff.en && awaddr == OFS_MODE && wdata[3:2] == BM_SIO
        && !r_ff.sck_wr && clk_en |=> r_ff.sck[0] == 1'b0)
        else $error("clock select bit0 not cleared");
    a_rx_not_tx: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hs && awaddr == OFS_DATA && r_ff.d2 == r_ff.dseen |=> $stable(r_ff.rx))
        else $error("written byte reached read side");
    a_tx_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r_ff.busy) && r_ff.src_mode != XM_RX |-> $past(r_ff.tx_full) ##1 r_ff.busy [*2])
        else $error("transmit started without byte");
endmodule // sio_ctrl

// ===== sio_peer.sv
// -----------------------------------------------------------------
// far-side serial device: shifts on the generated clock, lsb first
// -----------------------------------------------------------------
module sio_peer (
    input  wire logic       rst_n,    // low while the bench resets
    input  wire logic       sck,      // serial clock from the block
    input  wire logic       so,       // serial data from the block
    input  wire logic [7:0] tx_byte,  // byte this device sends back
    output logic            si,       // serial data to the block
    output logic [7:0]      rx_byte,  // last eight bits captured
    output int              nbits     // bits seen since time zero
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_byte = 8'h00;
        nbits   = 0;
    end

    // next bit changes right after the sampling edge, stable a full period
    assign si = tx_byte[nbits[2:0]];

    // capture on the rising edge, lsb arrives first
    always @(posedge sck) begin
        if (rst_n) begin
            rx_byte <= {so, rx_byte[7:1]};
            nbits   <= nbits + 1;
        end
    end
endmodule // sio_peer

// ===== tb_sync_serial_sio_control.sv
module tb_sync_serial_sio_control;
    import sio_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    logic        aclk = 1'b0;          // register clock
    logic        shift_clk = 1'b0;     // link clock
    logic        aresetn = 1'b0;       // sync reset
    logic        si_in, so_out, sck_out, sck_oe;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;    // rsp: last response code taken
    logic [7:0]  p_tx = 8'h00, p_rx;   // far-side bytes
    int          p_bits, base, bad_count = 0, n_tests = 0;
    logic [31:0] d;

    initial forever #12.5 aclk = ~aclk;
    initial forever #6 shift_clk = ~shift_clk;   // unrelated 12 ns clock

    sio_ctrl i_sio_ctrl (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .shift_clk(shift_clk),
        .si_in(si_in), .so_out(so_out), .sck_out(sck_out), .sck_oe(sck_oe),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    sio_peer i_sio_peer (.rst_n(aresetn), .sck(sck_out), .so(so_out), .tx_byte(p_tx),
        .si(si_in), .rx_byte(p_rx), .nbits(p_bits));
    // -----------------------------------------------------------------
    // bus tasks
    // -----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);   // both ready together
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            $display("BAD %s exp %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    // wait until the far side has seen n bits in total
    task automatic wait_bits(input int n);
        for (int k = 0; k < 4000 && p_bits < n; k++) @(posedge aclk);
    endtask
    // poll status until idle reads back
    task automatic wait_idle();
        d = 32'h0000_0000;
        for (int k = 0; k < 200 && d !== 32'h0000_00F3; k++) rd(OFS_MODE, d);
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_ENABLE, d); chk("enable rst", d, 32'h0000_0000);
        chk("rresp ok", {30'h0, rsp}, {30'h0, RESP_OKAY});
        rd(OFS_XFER, d); chk("xfer rst", d, 32'h0000_0009);
        rd(OFS_DATA, d); chk("data rst", d, 32'h0000_0000);
        rd(OFS_MODE, d); chk("status rst", d, 32'h0000_00F3);
        // unmapped offsets answer with a slave error and no effect
        rd(4'h2, d); chk("rresp unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        chk("rdata unmapped", d, 32'h0000_0000);
        wr(4'h6, 32'h0000_0080); chk("bresp unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        // a write to xfer while disabled is answered okay and leaves xfer alone
        wr(OFS_XFER, 32'h0000_0092);
        chk("bresp off", {30'h0, rsp}, {30'h0, RESP_OKAY});
        rd(OFS_XFER, d); chk("xfer off", d, 32'h0000_0009);
        // enable, select serial mode: clock select bit 0 drops
        wr(OFS_ENABLE, 32'h0000_0080);
        rd(OFS_ENABLE, d); chk("enable on", d, 32'h0000_0080);
        wr(OFS_MODE, 32'h0000_0004);
        rd(OFS_XFER, d); chk("sel bit0", d, 32'h0000_0008);
        // transmit and receive one byte at select 2
        wr(OFS_XFER, 32'h0000_0062);
        rd(OFS_XFER, d); chk("xfer cfg", d, 32'h0000_006A);
        p_tx <= 8'h3C;
        wr(OFS_DATA, 32'h0000_00A5);
        rd(OFS_DATA, d); chk("data wr hid", d, 32'h0000_0000);
        base = p_bits;
        wr(OFS_XFER, 32'h0000_00A2);
        wait_bits(base + 8);
        chk("peer rx", {24'h0, p_rx}, 32'h0000_00A5);
        chk("sck oe int", {31'h0, sck_oe}, 32'h0000_0001);
        wait_idle();
        rd(OFS_DATA, d); chk("data rx", d, 32'h0000_003C);
        // disable keeps settings, disabled writes to xfer ignored
        wr(OFS_XFER, 32'h0000_0062);
        wr(OFS_ENABLE, 32'h0000_0000);
        wr(OFS_XFER, 32'h0000_0000);
        rd(OFS_XFER, d); chk("xfer kept", d, 32'h0000_006A);
        wr(OFS_ENABLE, 32'h0000_0080);
        // receive only, no transmit byte needed
        p_tx <= 8'hC3;
        wr(OFS_XFER, 32'h0000_0072);
        base = p_bits;
        wr(OFS_XFER, 32'h0000_00B2);
        wait_bits(base + 8);
        wr(OFS_XFER, 32'h0000_0072);
        wait_idle();
        rd(OFS_DATA, d); chk("data rx only", d, 32'h0000_00C3);
        // reserved mode must not start
        wr(OFS_XFER, 32'h0000_0052);
        wr(OFS_DATA, 32'h0000_0011);
        base = p_bits;
        wr(OFS_XFER, 32'h0000_0092);
        repeat (300) @(posedge aclk);
        chk("rsv no start", p_bits - base, 32'h0000_0000);
        // external clock select releases the clock pin
        wr(OFS_XFER, 32'h0000_0067);
        repeat (10) @(posedge aclk);
        chk("sck oe ext", {31'h0, sck_oe}, 32'h0000_0000);
        chk("sck hi ext", {31'h0, sck_out}, 32'h0000_0001);
        // abort a slow transmit-and-receive byte in mid-flight
        p_tx <= 8'hFF;
        wr(OFS_XFER, 32'h0000_0066);
        wr(OFS_DATA, 32'h0000_00FF);
        base = p_bits;
        wr(OFS_XFER, 32'h0000_00A6);
        wait_bits(base + 2);
        wr(OFS_XFER, 32'h0000_0066);
        wait_idle();
        chk("abort idle", d, 32'h0000_00F3);
        repeat (600) @(posedge aclk);
        chk("abort short", {31'h0, (p_bits - base) < 8}, 32'h0000_0001);
        rd(OFS_DATA, d); chk("abort no rx", d, 32'h0000_00C3);
        // a full byte after the abort still reaches the read side
        wr(OFS_XFER, 32'h0000_0062);
        wr(OFS_DATA, 32'h0000_005A);
        base = p_bits;
        wr(OFS_XFER, 32'h0000_00A2);
        wait_bits(base + 8);
        chk("peer rx 2", {24'h0, p_rx}, 32'h0000_005A);
        wait_idle();
        rd(OFS_DATA, d); chk("rx after abort", d, 32'h0000_00FF);
        test_done();
    end

    // watchdog: whole run needs well under this span
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule // tb_sync_serial_sio_control
